/* vcc_comparator_control.sv */
`timescale 1ns/100ps
// What this block does
// - offers a clock-synchronous latched output and a raw unclocked output
// - raw output follows the comparator even with the clock stopped
// - disabled: routed outputs low and analog supply switched off
// - falling edge sets the fall flag, rising edge sets the rise flag
// - edge flags stay set until software writes zero
// - interrupt only for a set flag whose mask bit is one
// - bit 6 reads the present comparator result
// - bit 7 enables the comparator, reset to zero
// - bits 3:2 select positive hysteresis off, 5, 10 or 20 mV
// - bits 1:0 select negative hysteresis off, 5, 10 or 20 mV
// - software selects response time; slower means lower supply current
// - comparator output is offered to the reset logic
// - control register at 0x9b page 0, resets to zero, flags writable
// - two-bit speed field, 00 fastest, 11 slowest, reset value 10
// - rise and fall masks at bits 5 and 4 of register 0x9d, reset 0
`include "vcc_cfg.svh"
module vcc_comparator_control
	import vcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [3:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// analog comparator core
	input wire logic cmp_raw,
	output logic analog_power_on,
	output logic [1:0] pos_hyst_sel,
	output logic [1:0] neg_hyst_sel,
	output logic [1:0] response_speed_sel,
	// routed outputs, interrupt, reset source
	output logic latched_compare_out,
	output logic raw_compare_out,
	output logic compare_irq,
	output logic reset_source_out
);
	vcc_state_s s_q, s_d;
	logic rst_n;
	logic cmp_s, rise_ev, fall_ev, sel_ctrl, sel_spd, wr_ctrl, wr_spd;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	// reset is released through the first two stages of the state word
	assign rst_n = s_q.rst_sync[1];
	// ---------------------------------------------------------------
	// decode and edge detect
	// ---------------------------------------------------------------
	assign sel_ctrl = sfr_page == `VCC_PAGE_CTRL
		&& sfr_addr == `VCC_ADDR_CTRL;
	assign sel_spd = sfr_page == `VCC_PAGE_CTRL
		&& sfr_addr == `VCC_ADDR_SPEED;
	assign wr_ctrl = sfr_wr && sel_ctrl;
	assign wr_spd = sfr_wr && sel_spd;
	assign sfr_hit = (sfr_wr || sfr_rd) && (sel_ctrl || sel_spd);
	// gated by enable so a disabled comparator reads low
	assign cmp_s = s_q.cmp_sync[1] & s_q.on;
	assign rise_ev = cmp_s & ~s_q.cmp_prev;
	assign fall_ev = ~cmp_s & s_q.cmp_prev;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
		s_d.cmp_sync = {s_q.cmp_sync[0], cmp_raw};
		s_d.cmp_prev = cmp_s;
		if (wr_ctrl)
		begin
			s_d.on = sfr_wdata[`VCC_BIT_ON];
			s_d.pos_hyst = sfr_wdata[`VCC_POS_HI:`VCC_POS_LO];
			s_d.neg_hyst = sfr_wdata[`VCC_NEG_HI:`VCC_NEG_LO];
			// writing one leaves a flag alone; only zero clears it
			s_d.rise_flag = s_q.rise_flag & sfr_wdata[`VCC_BIT_RISE];
			s_d.fall_flag = s_q.fall_flag & sfr_wdata[`VCC_BIT_FALL];
		end
		if (wr_spd)
		begin
			s_d.rise_mask = sfr_wdata[`VCC_BIT_RISE_MASK];
			s_d.fall_mask = sfr_wdata[`VCC_BIT_FALL_MASK];
			s_d.speed = sfr_wdata[`VCC_SPD_HI:`VCC_SPD_LO];
		end
		// set wins over a clear in the same cycle
		if (rise_ev)
			s_d.rise_flag = 1'b1;
		if (fall_ev)
			s_d.fall_flag = 1'b1;
		s_d.rdata = 8'h00;
		if (sel_ctrl)
		begin
			s_d.rdata[`VCC_BIT_ON] = s_q.on;
			s_d.rdata[`VCC_BIT_RESULT] = cmp_s;
			s_d.rdata[`VCC_BIT_RISE] = s_q.rise_flag;
			s_d.rdata[`VCC_BIT_FALL] = s_q.fall_flag;
			s_d.rdata[`VCC_POS_HI:`VCC_POS_LO] = s_q.pos_hyst;
			s_d.rdata[`VCC_NEG_HI:`VCC_NEG_LO] = s_q.neg_hyst;
		end
		else if (sel_spd)
		begin
			s_d.rdata[`VCC_BIT_RISE_MASK] = s_q.rise_mask;
			s_d.rdata[`VCC_BIT_FALL_MASK] = s_q.fall_mask;
			s_d.rdata[`VCC_SPD_HI:`VCC_SPD_LO] = s_q.speed;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s_q <= '{rst_sync: 2'h0, cmp_sync: 2'h0, cmp_prev: 1'b0,
				on: 1'b0, rise_flag: 1'b0, fall_flag: 1'b0,
				pos_hyst: 2'h0, neg_hyst: 2'h0, rise_mask: 1'b0,
				fall_mask: 1'b0, speed: `VCC_SPEED_RESET,
				rdata: `VCC_CTRL_RESET};
		else if (!rst_n)
			s_q <= '{rst_sync: s_d.rst_sync, cmp_sync: 2'h0,
				cmp_prev: 1'b0, on: 1'b0, rise_flag: 1'b0,
				fall_flag: 1'b0, pos_hyst: 2'h0, neg_hyst: 2'h0,
				rise_mask: 1'b0, fall_mask: 1'b0,
				speed: `VCC_SPEED_RESET, rdata: `VCC_CTRL_RESET};
		else
			s_q <= s_d;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sfr_rdata = s_q.rdata;
	assign analog_power_on = s_q.on;
	assign pos_hyst_sel = s_q.pos_hyst;
	assign neg_hyst_sel = s_q.neg_hyst;
	assign response_speed_sel = s_q.speed;
	// the last sampled result can still be high in the cycle after a
	// disable, so the enable gates the flop output as well
	assign latched_compare_out = s_q.cmp_prev & s_q.on;
	// no flop in this path, so it keeps working with the clock stopped
	assign raw_compare_out = cmp_raw & s_q.on;
	assign reset_source_out = cmp_s;
	assign compare_irq = (s_q.rise_flag & s_q.rise_mask)
		| (s_q.fall_flag & s_q.fall_mask);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_rise_sets: assert property (rise_ev |=> s_q.rise_flag)
		else $error("rise flag not set");
	a_fall_sets: assert property (fall_ev |=> s_q.fall_flag)
		else $error("fall flag not set");
	a_flag_sticky: assert property (s_q.rise_flag && !wr_ctrl
		|=> s_q.rise_flag)
		else $error("rise flag dropped");
	a_irq_gate: assert property (compare_irq == ((s_q.rise_flag
		&& s_q.rise_mask) || (s_q.fall_flag && s_q.fall_mask)))
		else $error("irq gating wrong");
	a_off_low: assert property (!s_q.on |-> !raw_compare_out
		&& !latched_compare_out && !analog_power_on)
		else $error("disabled output not low");
	a_sync_path: assert property (s_q.on && $past(s_q.on, 3)
		|-> cmp_s == $past(cmp_raw, 2))
		else $error("sync delay wrong");
	a_enable_write: assert property (wr_ctrl
		|=> s_q.on == $past(sfr_wdata[7]))
		else $error("enable not written");
	a_speed_write: assert property (wr_spd
		|=> response_speed_sel == $past(sfr_wdata[1:0]))
		else $error("speed not written");
	a_hyst_write: assert property (wr_ctrl
		|=> pos_hyst_sel == $past(sfr_wdata[3:2])
		&& neg_hyst_sel == $past(sfr_wdata[1:0]))
		else $error("hysteresis not written");
	a_result_read: assert property (sfr_rd && sel_ctrl
		|=> sfr_rdata[6] == $past(cmp_s))
		else $error("result bit wrong");
	a_fall_sticky: assert property (s_q.fall_flag && !wr_ctrl
		|=> s_q.fall_flag)
		else $error("fall flag dropped");
	a_flag_clear: assert property (wr_ctrl && !sfr_wdata[5] && !rise_ev
		|=> !s_q.rise_flag)
		else $error("rise flag not cleared");
	a_unmapped_read: assert property (!sel_ctrl && !sel_spd
		|=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_latched_follow: assert property (s_q.on && $past(s_q.on)
		|-> latched_compare_out == $past(cmp_s))
		else $error("latched output wrong");
	a_mask_write: assert property (wr_spd
		|=> s_q.rise_mask == $past(sfr_wdata[5])
		&& s_q.fall_mask == $past(sfr_wdata[4]))
		else $error("masks not written");

	c_rise: cover property (rise_ev ##1 compare_irq);
	c_fall: cover property (fall_ev ##1 s_q.fall_flag);
	c_clear: cover property (s_q.rise_flag ##1 wr_ctrl ##1 !s_q.rise_flag);
	c_set_clear: cover property (rise_ev && wr_ctrl);
endmodule // vcc_comparator_control

/* vcc_cfg.svh */
`ifndef VCC_CFG_SVH
`define VCC_CFG_SVH
// ---------------------------------------------------------------
// register addresses (special-function space, page 0)
// ---------------------------------------------------------------
`define VCC_ADDR_CTRL 8'h9b
`define VCC_ADDR_SPEED 8'h9d
`define VCC_PAGE_CTRL 4'h0
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define VCC_BIT_ON 7
`define VCC_BIT_RESULT 6
`define VCC_BIT_RISE 5
`define VCC_BIT_FALL 4
`define VCC_POS_HI 3
`define VCC_POS_LO 2
`define VCC_NEG_HI 1
`define VCC_NEG_LO 0
`define VCC_CTRL_RESET 8'h00
// ---------------------------------------------------------------
// speed register fields
// ---------------------------------------------------------------
`define VCC_BIT_RISE_MASK 5
`define VCC_BIT_FALL_MASK 4
`define VCC_SPD_HI 1
`define VCC_SPD_LO 0
`define VCC_SPEED_RESET 2'h2
`endif

/* vcc_pkg.sv */
package vcc_pkg;
	typedef logic [1:0] vcc_hyst_t;
	typedef logic [1:0] vcc_speed_t;
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] cmp_sync;
		logic cmp_prev;
		logic on;
		logic rise_flag;
		logic fall_flag;
		vcc_hyst_t pos_hyst;
		vcc_hyst_t neg_hyst;
		logic rise_mask;
		logic fall_mask;
		vcc_speed_t speed;
		logic [7:0] rdata;
	} vcc_state_s;
endpackage

/* vcc_cmp_model.sv */
`timescale 1ns/100ps
module vcc_cmp_model
(
	// level the bench wants on the comparator
	input wire logic level,
	// analog core pins
	input wire logic analog_power_on,
	output logic cmp_raw
);
	// an unpowered core gives no valid answer, so it chatters
	logic junk = 1'b0;
	always #7 junk = ~junk;
	assign cmp_raw = analog_power_on ? level : junk;
endmodule // vcc_cmp_model

/* vcc_comparator_control_test.sv */
`timescale 1ns/100ps
`include "vcc_cfg.svh"
module vcc_comparator_control_test;
	import vcc_pkg::*;
	localparam logic [7:0] ct = `VCC_ADDR_CTRL;
	localparam logic [7:0] sp = `VCC_ADDR_SPEED;
	logic clk = 1'b0;
	logic clk_run = 1'b1;
	logic rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [3:0] pg = 4'h0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata, v;
	logic level = 1'b0;
	logic sfr_hit, cmp_raw, pwr, lat, raw, irq, rsrc;
	logic [1:0] hp, hn, spd;
	int err_total = 0;
	int samples_checked = 0;
	// gated so the raw path can be seen with no clock
	always #10 clk = clk_run ? ~clk : clk;
	vcc_comparator_control u_vcc_comparator_control (.clk(clk), .rstn(rstn),
		.sfr_addr(sfr_addr), .sfr_page(pg), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .cmp_raw(cmp_raw), .analog_power_on(pwr),
		.pos_hyst_sel(hp), .neg_hyst_sel(hn), .response_speed_sel(spd),
		.latched_compare_out(lat), .raw_compare_out(raw),
		.compare_irq(irq), .reset_source_out(rsrc));
	vcc_cmp_model u_vcc_cmp_model (.level(level),
		.analog_power_on(pwr), .cmp_raw(cmp_raw));
	// ---------------------------------------------------------------
	// access and compare tasks
	// ---------------------------------------------------------------
	task automatic cmp1(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic cmp8(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		#1 cmp1("hit", ((a == ct) || (a == sp)) && (pg == 4'h0),
			sfr_hit);
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 cmp8("rdata", e, sfr_rdata);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		if ((err_total == 0) && (samples_checked > 0))
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial
	begin
		#100000;
		err_total++;
		complete_run;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ct, `VCC_CTRL_RESET);
		rd(sp, {6'h00, `VCC_SPEED_RESET});
		wr(8'h9c, 8'hff);
		rd(8'h9c, 8'h00);
		wr(ct, 8'h80);
		tick(4);
		for (int i = 0; i < 4; i++)
		begin
			v = 8'h80 | 8'(i << 2) | 8'(3 - i);
			wr(ct, v | 8'h40);
			wr(sp, 8'hcc | 8'(i));
			rd(ct, v);
			rd(sp, 8'(i));
			cmp8("hyst", {4'h0, v[3:0]}, {4'h0, hp, hn});
			cmp8("speed", 8'(i), {6'h00, spd});
		end
		wr(sp, 8'h02);
		wr(ct, 8'h80);
		level <= 1'b1;
		tick(5);
		cmp8("outs", 8'h0f, {4'h0, pwr, lat, raw, rsrc});
		cmp1("irq", 1'b0, irq);
		rd(ct, 8'he0);
		wr(sp, 8'h22);
		tick(1);
		cmp1("irq", 1'b1, irq);
		level <= 1'b0;
		tick(20);
		rd(ct, 8'hb0);
		wr(ct, 8'ha0);
		rd(ct, 8'ha0);
		pg <= 4'h1;
		wr(ct, 8'h00);
		rd(ct, 8'h00);
		pg <= 4'h0;
		rd(ct, 8'ha0);
		wr(sp, 8'h12);
		tick(1);
		cmp1("irq", 1'b0, irq);
		level <= 1'b1;
		tick(5);
		@(negedge clk);
		clk_run = 1'b0;
		level = 1'b0;
		#50 cmp1("raw_stopped", 1'b0, raw);
		level = 1'b1;
		#50 cmp1("raw_stopped", 1'b1, raw);
		clk_run = 1'b1;
		wr(ct, 8'h00);
		tick(4);
		cmp8("off", 8'h00, {4'h0, pwr, lat, raw, rsrc});
		complete_run;
	end
endmodule // vcc_comparator_control_test
